// *** hw/bus_front.sv ***
// Purpose: address, byte-enable, strobe and reset state of the external bus front end
// Assumes: core requests are synchronous to i_clk; cycle ends on i_done
// Notes:   ready/sizing handshakes live elsewhere; cycle-type encoding (M/IO, D/C, W/R) is set here from i_kind, i_code, i_write
`timescale 1ns/1ps
`default_nettype none
module bus_front #(
  parameter int unsigned FETCH_DELAY = bus_front_pkg::FETCH_DELAY_CLKS
) (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // core request
  input  wire logic        i_req,
  input  wire logic [1:0]  i_kind,
  input  wire logic        i_write,
  input  wire logic        i_code,
  input  wire logic        i_copro_data,
  input  wire logic [29:0] i_word_addr,
  input  wire logic [3:0]  i_be_n,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_done,
  input  wire logic        i_hold_grant,
  // bus pins
  output logic [29:0]      o_word_address_lines,
  output logic             o_addr_oe,
  output logic [3:0]       o_byte_lane_enables_n,
  output logic             o_address_strobe_n,
  output logic             o_mem_io,
  output logic             o_data_ctrl,
  output logic             o_write_read,
  output logic             o_lock_n,
  output logic             o_hold_acknowledge_out,
  output logic [31:0]      o_data_lines,
  output logic             o_data_oe,
  output logic             o_cache_replacement_set,
  output logic             o_cache_replacement_valid_n,
  output logic             o_suspend_acknowledge_n,
  output logic             o_repl_oe,
  output logic             o_susp_oe,
  // status
  output logic             o_phase,
  output logic             o_busy
);
  localparam int CW = $clog2(FETCH_DELAY + 1);

  bus_front_pkg::bus_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [29:0] addr_reg, addr_next;
  logic [3:0]  be_reg, be_next;
  logic        strobe_reg, strobe_next, mio_reg, mio_next, dc_reg, dc_next, wr_reg, wr_next;
  logic        lock_reg, lock_next, hold_ack_reg, hold_ack_next, aoe_reg, aoe_next;
  logic        doe_reg, doe_next;
  logic [31:0] data_reg, data_next;
  logic        phase_raw;

  phase_divider u_div (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .o_phase (phase_raw)
  );

  // duplicate upper bytes into the lower lanes on memory writes
  function automatic logic [31:0] dup_data(input logic [3:0] be_n, input logic [31:0] d);
    case (be_n)
      4'h3:    dup_data = {d[31:16], d[31:16]};
      4'h7:    dup_data = {d[31:24], d[23:16], d[31:24], d[7:0]};
      4'hB:    dup_data = {d[31:24], d[23:8], d[23:16]};
      default: dup_data = d;                                    // lane n = byte n
    endcase
  endfunction : dup_data

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    be_next    = be_reg;
    strobe_next = 1'b1;
    mio_next   = mio_reg;
    dc_next    = dc_reg;
    wr_next    = wr_reg;
    lock_next  = 1'b1;
    hold_ack_next = 1'b0;
    aoe_next   = 1'b1;
    doe_next   = 1'b0;
    data_next  = data_reg;
    if (i_rst) begin                                            // inputs ignored here
      state_next = bus_front_pkg::ST_WAIT;                     // abort all in flight
      cnt_next   = '0;
      addr_next  = bus_front_pkg::ADDR_RESET_VAL;
      be_next    = bus_front_pkg::BE_RESET_VAL;
      mio_next   = 1'b0;
      dc_next    = 1'b1;
      wr_next    = 1'b0;
    end else begin
      case (state_reg)
        bus_front_pkg::ST_RESET: state_next = bus_front_pkg::ST_WAIT;
        bus_front_pkg::ST_WAIT: begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == CW'(FETCH_DELAY - 1)) begin
            state_next = bus_front_pkg::ST_CYCLE;
            addr_next  = bus_front_pkg::RESET_VECTOR[31:2];    // first cycle: code fetch
            be_next    = bus_front_pkg::BE_ALL_ON;
            mio_next   = 1'b1;
            dc_next    = 1'b0;
            wr_next    = 1'b0;
            strobe_next = 1'b0;                                 // strobe with valid address
          end
        end
        bus_front_pkg::ST_IDLE: begin
          if (i_hold_grant) begin
            hold_ack_next = 1'b1;
            aoe_next  = 1'b0;                                   // float address
          end else if (i_req && bus_front_pkg::be_legal(i_be_n)) begin
            state_next = bus_front_pkg::ST_CYCLE;
            strobe_next = 1'b0;
            be_next    = i_be_n;
            wr_next    = i_write;
            dc_next    = ~i_code;
            case (i_kind)
              2'(bus_front_pkg::KIND_IO): begin
                // word lines 29..14 carry address bits 31..16, all forced low
                addr_next = {bus_front_pkg::IO_UPPER_ZERO, i_word_addr[13:0]};
                mio_next  = 1'b0;
              end
              2'(bus_front_pkg::KIND_COPRO): begin
                addr_next = i_copro_data ? bus_front_pkg::COPRO_DATA_ADDR[31:2]
                                         : bus_front_pkg::COPRO_CMD_ADDR[31:2];
                mio_next  = 1'b0;
              end
              default: begin
                addr_next = i_word_addr;                        // full 30 lines
                mio_next  = 1'b1;
              end
            endcase
            if (i_write) begin
              doe_next  = 1'b1;                                 // drive only on writes
              data_next = (i_kind == 2'(bus_front_pkg::KIND_MEM)) ? dup_data(i_be_n, i_wdata)
                                                                  : i_wdata;
            end
          end
        end
        bus_front_pkg::ST_CYCLE: begin
          doe_next = wr_reg;
          if (i_done) begin
            state_next = bus_front_pkg::ST_IDLE;
            doe_next   = 1'b0;
          end
        end
        default: state_next = bus_front_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin                              // all on rising edge
    if (i_ce) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      be_reg    <= be_next;
      strobe_reg <= strobe_next;
      mio_reg   <= mio_next;
      dc_reg    <= dc_next;
      wr_reg    <= wr_next;
      lock_reg  <= lock_next;
      hold_ack_reg <= hold_ack_next;
      aoe_reg   <= aoe_next;
      doe_reg   <= doe_next;
      data_reg  <= data_next;
      o_phase   <= phase_raw;
      o_busy    <= (state_next != bus_front_pkg::ST_IDLE);
    end
  end

  // outputs straight from flops or tied constant; active-low names end _n
  always_comb begin
    o_word_address_lines        = addr_reg;
    o_addr_oe                   = aoe_reg;
    o_byte_lane_enables_n       = be_reg;
    o_address_strobe_n          = strobe_reg;
    o_mem_io                    = mio_reg;
    o_data_ctrl                 = dc_reg;
    o_write_read                = wr_reg;
    o_lock_n                    = lock_reg;
    o_hold_acknowledge_out      = hold_ack_reg;
    o_data_lines                = data_reg;
    o_data_oe                   = doe_reg;
    o_cache_replacement_set     = 1'b0;   // floated: enables below stay low
    o_cache_replacement_valid_n = 1'b1;
    o_suspend_acknowledge_n     = 1'b1;
    o_repl_oe                   = 1'b0;
    o_susp_oe                   = 1'b0;
  end

  // checks
  property p_reset_state;
    @(posedge i_clk) (i_rst && i_ce) |=> (o_word_address_lines == 30'h3FFF_FFFF
      && o_byte_lane_enables_n == 4'h0 && o_address_strobe_n && !o_mem_io && !o_data_oe);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_first_fetch;
    @(posedge i_clk) disable iff (i_rst)
      (!o_address_strobe_n && $past(state_reg) == bus_front_pkg::ST_WAIT)
      |-> (o_word_address_lines == 30'h3FFF_FFFC && o_mem_io && !o_data_ctrl && !o_write_read
           && o_byte_lane_enables_n == 4'h0);
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("bad first fetch");

  property p_hold_float;
    @(posedge i_clk) disable iff (i_rst) o_hold_acknowledge_out |-> (!o_addr_oe && !o_data_oe);
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("drives in hold");

  property p_io_upper;
    @(posedge i_clk) disable iff (i_rst)
      (!o_address_strobe_n && !o_mem_io) |-> (o_word_address_lines[29:14] == 16'h0000
        || o_word_address_lines == 30'h2000_003E || o_word_address_lines == 30'h2000_003F);
  endproperty
  a_io_upper: assert property (p_io_upper) else $error("io upper bits set");

  property p_be_legal;
    @(posedge i_clk) disable iff (i_rst)
      !o_address_strobe_n |-> bus_front_pkg::be_legal(o_byte_lane_enables_n);
  endproperty
  a_be_legal: assert property (p_be_legal) else $error("illegal enables");

  property p_dup;
    @(posedge i_clk) disable iff (i_rst)
      (!o_address_strobe_n && o_write_read && o_mem_io && o_byte_lane_enables_n == 4'h3)
      |-> (o_data_lines[15:0] == o_data_lines[31:16]);
  endproperty
  a_dup: assert property (p_dup) else $error("no duplication");

  property p_read_float;
    @(posedge i_clk) disable iff (i_rst) (!o_write_read) |-> !o_data_oe;
  endproperty
  a_read_float: assert property (p_read_float) else $error("data driven on read");

  property p_wait_quiet;
    @(posedge i_clk) disable iff (i_rst)
      (state_reg == bus_front_pkg::ST_WAIT) |-> (o_address_strobe_n && !o_hold_acknowledge_out);
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("bus active before fetch");

  c_fetch: cover property (@(posedge i_clk) !o_address_strobe_n && o_mem_io && !o_data_ctrl);
  c_copro: cover property (@(posedge i_clk) !o_address_strobe_n && o_word_address_lines[29]);
  c_hold:  cover property (@(posedge i_clk) o_hold_acknowledge_out);
endmodule : bus_front
`default_nettype wire

// *** common/bus_front_pkg.sv ***
// Purpose: constants for the external bus front end (clock, reset, address forms)
// Assumes: one clock i_clk is the double-rate clock input, 250 MHz
// Notes:   offsets, address and byte-enable reset values and counts live here
package bus_front_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned FETCH_DELAY_CLKS  = 400;   // double-rate periods after reset
  localparam logic [31:0] RESET_VECTOR      = 32'hFFFF_FFF0;
  localparam logic [31:0] COPRO_CMD_ADDR    = 32'h8000_00F8;
  localparam logic [31:0] COPRO_DATA_ADDR   = 32'h8000_00FC;
  localparam logic [15:0] IO_UPPER_ZERO     = 16'h0000;
  localparam logic [29:0] ADDR_RESET_VAL    = 30'h3FFF_FFFF;
  localparam logic [3:0]  BE_RESET_VAL      = 4'h0;
  localparam logic [3:0]  BE_ALL_ON         = 4'h0;

  // access kinds requested by the core side
  typedef enum logic [1:0] {
    KIND_MEM   = 2'h0,
    KIND_IO    = 2'h1,
    KIND_COPRO = 2'h2
  } access_kind_t;

  // bus sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_WAIT  = 4'h2,
    ST_IDLE  = 4'h4,
    ST_CYCLE = 4'h8
  } bus_state_t;

  // true for the byte-enable patterns the bus may produce
  function automatic logic be_legal(input logic [3:0] be_n);
    case (be_n)
      4'h0, 4'h1, 4'h3, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE: be_legal = 1'b1;
      default: be_legal = 1'b0;
    endcase
  endfunction : be_legal
endpackage : bus_front_pkg

// *** hw/phase_divider.sv ***
// Purpose: divide the double-rate clock by two as a phase enable
// Assumes: i_rst synchronous, active high
// Notes:   phase restarts on the falling edge of reset
`timescale 1ns/1ps
`default_nettype none
module phase_divider (
  // clock and control
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // divided phase
  output logic      o_phase
);
  logic phase_reg;
  logic phase_next;

  always_comb begin
    phase_next = ~phase_reg;
    if (i_rst) begin
      phase_next = 1'b0;                   // held at known phase, released in step
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      phase_reg <= phase_next;             // toggle: divide by two
    end
  end

  assign o_phase = phase_reg;
endmodule : phase_divider
`default_nettype wire

// *** tb/bus_responder.sv ***
// Purpose: far-side model that ends each bus cycle after a set delay
// Assumes: i_delay is stable while a cycle is open
// Notes:   also decodes low byte address bits and coprocessor select
`timescale 1ns/1ps
`default_nettype none
module bus_responder (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // bus pins seen
  input  wire logic        i_address_strobe_n,
  input  wire logic [29:0] i_word_address_lines,
  input  wire logic [3:0]  i_byte_lane_enables_n,
  input  wire logic        i_mem_io,
  input  wire logic [7:0]  i_delay,
  // answers
  output logic             o_done,
  output logic [1:0]       o_low_addr,
  output logic             o_copro_sel
);
  logic       open_reg;
  logic [7:0] cnt_reg;
  wire  [3:0] b = i_byte_lane_enables_n;
  // sampled and changed on the rising edge only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      open_reg <= 1'b0;
      cnt_reg  <= 8'h00;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!i_address_strobe_n) begin
        open_reg <= 1'b1;
        cnt_reg  <= i_delay;
      end else if (open_reg && cnt_reg == 8'h00) begin
        o_done   <= 1'b1;
        open_reg <= 1'b0;
      end else if (open_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  // active-low enables decoded to byte offset
  assign o_low_addr  = {b[0] & b[1], (b[0] & b[2]) | (b[0] & ~b[1])};
  // memory cycles may also carry bit 31 high, so decode io space only
  assign o_copro_sel = i_word_address_lines[29] & ~i_mem_io;
endmodule : bus_responder
`default_nettype wire

// *** tb/bus_front_tb_top.sv ***
// Purpose: self-checking bench for the bus front end
// Assumes: short fetch delay parameter, responder ends cycles
// Notes:   undefined byte lanes are masked out of data checks
`timescale 1ns/1ps
`default_nettype none
module bus_front_tb_top;
  localparam int unsigned FD = 8;
  logic i_clk, i_rst, i_ce, i_req, i_write, i_code, i_copro_data, i_done, i_hold_grant;
  logic [1:0]  i_kind;
  logic [29:0] i_word_addr, addr;
  logic [3:0]  i_be_n, be_n;
  logic [31:0] i_wdata, data;
  logic addr_oe, stb_n, mem_io, dc, wr, lock_n, hold_ack, data_oe, rset, rval_n, susp_n;
  logic repl_oe, susp_oe, phase, busy, csel, ph_ref;
  logic [7:0]  dly;
  logic [1:0]  low;
  logic [29:0] exp_q[$];
  logic [3:0]  legal[10] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE};
  int mismatches, tests_run;
  bus_front #(.FETCH_DELAY(FD)) bus_front_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_req(i_req), .i_kind(i_kind), .i_write(i_write), .i_code(i_code),
    .i_copro_data(i_copro_data), .i_word_addr(i_word_addr), .i_be_n(i_be_n),
    .i_wdata(i_wdata), .i_done(i_done), .i_hold_grant(i_hold_grant),
    .o_word_address_lines(addr), .o_addr_oe(addr_oe), .o_byte_lane_enables_n(be_n),
    .o_address_strobe_n(stb_n), .o_mem_io(mem_io), .o_data_ctrl(dc), .o_write_read(wr),
    .o_lock_n(lock_n), .o_hold_acknowledge_out(hold_ack), .o_data_lines(data),
    .o_data_oe(data_oe), .o_cache_replacement_set(rset),
    .o_cache_replacement_valid_n(rval_n), .o_suspend_acknowledge_n(susp_n),
    .o_repl_oe(repl_oe), .o_susp_oe(susp_oe), .o_phase(phase), .o_busy(busy));
  bus_responder bus_responder_i (.i_clk(i_clk), .i_rst(i_rst), .i_address_strobe_n(stb_n),
    .i_word_address_lines(addr), .i_byte_lane_enables_n(be_n), .i_mem_io(mem_io),
    .i_delay(dly),
    .o_done(i_done), .o_low_addr(low), .o_copro_sel(csel));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wait_on(input logic want, input logic sig_sel, output int n);
    n = 0;
    while ((sig_sel ? hold_ack : ~stb_n) !== want) begin
      tick();
      n++;
      if (n > FD + 60) begin
        mismatches++;
        end_of_test();
      end
    end
  endtask : wait_on
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
    cmp("idle", 32'h0000_0001, {31'h0, n < 100});
    if (n >= 100) begin
      end_of_test();
    end
    tick();
  endtask : wait_idle
  task automatic do_reset();
    int n;
    i_rst = 1'b1;
    i_req = 1'b1; // ignored while reset stands
    i_hold_grant = 1'b1;
    repeat (3) tick();
    cmp("rst_addr", {2'h0, bus_front_pkg::ADDR_RESET_VAL}, {2'h0, addr});
    cmp("rst_be", {28'h0, bus_front_pkg::BE_RESET_VAL}, {28'h0, be_n});
    cmp("rst_ctl", 32'h0000_01C0, {23'h0, stb_n, dc, lock_n, mem_io, wr, hold_ack, data_oe,
        repl_oe, susp_oe});
    i_req = 1'b0;
    i_hold_grant = 1'b0;
    i_rst = 1'b0;
    wait_on(1'b1, 1'b0, n);
    cmp("fetch_delay", 32'h0000_0001, {31'h0, n >= FD && n <= FD + 2});
    cmp("fetch_addr", 32'h3FFF_FFFC, {2'h0, addr});
    cmp("fetch_def", 32'h0000_0012, {27'h0, mem_io, dc, wr, be_n == 4'h0, 1'b0});
    // divider held at 0 in reset, toggles from release; the output trails one edge
    ph_ref = 1'((FD - 1) % 2);
    cmp("phase_align", {31'h0, ph_ref}, {31'h0, phase});
    tick();
    cmp("phase_div", {31'h0, ~ph_ref}, {31'h0, phase});
    wait_idle();
    $display("test reset done");
  endtask : do_reset
  task automatic bus_cycle(input logic [1:0] k, input logic w, input logic c, input logic cd,
                           input logic [29:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    int lo;
    logic [31:0] m, e;
    i_kind = k; i_write = w; i_code = c; i_copro_data = cd;
    i_word_addr = a; i_be_n = b; i_wdata = d; i_req = 1'b1;
    exp_q.push_back(k == bus_front_pkg::KIND_MEM ? a : k == bus_front_pkg::KIND_IO ?
                    a & 30'h0000_3FFF : (cd ? 30'h2000_003F : 30'h2000_003E));
    wait_on(1'b1, 1'b0, n);
    i_req = 1'b0;
    cmp("addr", {2'h0, exp_q.pop_front()}, {2'h0, addr});
    cmp("def", {29'h0, k == bus_front_pkg::KIND_MEM, ~c, w}, {29'h0, mem_io, dc, wr});
    cmp("be", {28'h0, b}, {28'h0, be_n});
    lo = 0;
    for (int i = 3; i >= 0; i--) if (!b[i]) lo = i;
    cmp("low_addr", lo, {30'h0, low});
    cmp("copro_sel", {31'h0, k == bus_front_pkg::KIND_COPRO}, {31'h0, csel});
    cmp("data_oe", {31'h0, w}, {31'h0, data_oe});
    m = 32'h0;
    e = d;
    for (int i = 0; i < 4; i++) if (!b[i]) m[8*i+:8] = 8'hFF;
    if (w && k == bus_front_pkg::KIND_MEM) begin
      case (b)
        4'h3: begin e[15:0] = d[31:16]; m[15:0] = 16'hFFFF; end
        4'h7: begin e[15:8] = d[31:24]; m[15:8] = 8'hFF; end
        4'hB: begin e[7:0] = d[23:16]; m[7:0] = 8'hFF; end
        default: ;
      endcase
    end
    if (w) cmp("wdata", e & m, data & m);
    tick();
    cmp("strobe_pulse", 32'h0000_0001, {31'h0, stb_n});
    wait_idle();
    cmp("data_released", 32'h0, {31'h0, data_oe});
  endtask : bus_cycle
  initial begin
    int n;
    i_rst = 1'b1; i_ce = 1'b1; i_req = 1'b0; i_kind = 2'h0; i_write = 1'b0; i_code = 1'b0;
    i_copro_data = 1'b0; i_word_addr = 30'h0; i_be_n = 4'h0; i_wdata = 32'h0;
    i_hold_grant = 1'b0; dly = 8'h02; ph_ref = 1'bx; mismatches = 0; tests_run = 0;
    n = $urandom(32'hafa9);
    #1;
    do_reset();
    foreach (legal[j]) begin
      dly = 8'($urandom % 4);
      bus_cycle(bus_front_pkg::KIND_MEM, 1'b1, 1'b0, 1'b0, 30'($urandom), legal[j], $urandom);
      bus_cycle(bus_front_pkg::KIND_MEM, 1'b0, j[0], 1'b0, 30'($urandom), legal[j], 32'h0);
    end
    $display("test memory done");
    bus_cycle(bus_front_pkg::KIND_IO, 1'b1, 1'b0, 1'b0, 30'($urandom), 4'hC, $urandom);
    bus_cycle(bus_front_pkg::KIND_IO, 1'b0, 1'b0, 1'b0, 30'($urandom), 4'h0, 32'h0);
    bus_cycle(bus_front_pkg::KIND_COPRO, 1'b1, 1'b0, 1'b0, 30'h0, 4'h0, $urandom);
    bus_cycle(bus_front_pkg::KIND_COPRO, 1'b1, 1'b0, 1'b1, 30'h0, 4'h0, $urandom);
    $display("test io done");
    // illegal pattern held up must never start a cycle
    i_be_n = 4'h5; i_kind = 2'h0; i_req = 1'b1;
    repeat (5) begin
      tick();
      cmp("illegal_be", 32'h0000_0001, {31'h0, stb_n});
    end
    i_req = 1'b0;
    i_be_n = 4'h0;
    tick();
    i_hold_grant = 1'b1;
    wait_on(1'b1, 1'b1, n);
    i_req = 1'b1;
    repeat (3) tick();
    cmp("hold_float", 32'h0000_0001, {29'h0, addr_oe, data_oe, stb_n});
    i_hold_grant = 1'b0;
    i_req = 1'b0;
    wait_on(1'b0, 1'b1, n);
    tick();
    $display("test hold done");
    // clock enable low freezes all state, even with a legal request standing
    ph_ref = phase;
    i_ce = 1'b0;
    i_req = 1'b1;
    repeat (3) begin
      tick();
      cmp("ce_freeze", {30'h0, ph_ref, 1'b1}, {30'h0, phase, stb_n});
    end
    i_ce = 1'b1;
    i_req = 1'b0;
    tick();
    $display("test enable done");
    // reset lands in mid-cycle while the far side is still slow
    dly = 8'h28; i_write = 1'b1; i_req = 1'b1;
    wait_on(1'b1, 1'b0, n);
    i_req = 1'b0;
    tick();
    do_reset();
    $display("test abort done");
    end_of_test();
  end
endmodule : bus_front_tb_top
`default_nettype wire
